/* hdl/bvc_pkg.sv */
// constants, register map and types for the buck voltage-code command register bank
// assumes a single 20 MHz clock domain; i2c pins are taken as synchronous inputs
package bvc_pkg;
    // target address on the two-wire bus (arbitrary neutral default)
    localparam logic [6:0] BVC_TARGET_ADDR = 7'h2A;
    // register offsets
    localparam logic [7:0] BVC_OFS_CH2_VSEL = 8'h01;
    localparam logic [7:0] BVC_OFS_CH3_VSEL = 8'h02;
    localparam logic [7:0] BVC_OFS_CH1_CMD = 8'h03;
    localparam logic [7:0] BVC_OFS_CH2_CMD = 8'h04;
    // reset value of every register
    localparam logic [7:0] BVC_REG_RESET = 8'h00;
    // field positions
    localparam int BVC_APPLY_BIT = 7;
    localparam int BVC_SLEW_MSB = 6;
    localparam int BVC_SLEW_LSB = 4;
    localparam int BVC_LIGHT_LOAD_BIT = 1;
    localparam int BVC_OFF_BIT = 0;
    // voltage code mapping in millivolts
    localparam int BVC_VMIN_MV = 680;
    localparam int BVC_VMAX_MV = 1950;
    localparam int BVC_VSTEP_MV = 10;
    localparam logic [6:0] BVC_CODE_MIN = 7'h00;
    localparam logic [6:0] BVC_CODE_MAX = 7'h7F;
    // clock
    localparam int BVC_CLK_NS = 50;
    // bus engine states
    typedef enum logic [2:0] {
        BVC_IDLE = 3'b000,
        BVC_ADDR = 3'b001,
        BVC_REGA = 3'b010,
        BVC_WDAT = 3'b011,
        BVC_RDAT = 3'b100,
        BVC_ACK = 3'b101,
        BVC_RACK = 3'b110,
        BVC_SKIP = 3'b111
    } bvc_state_t;
endpackage : bvc_pkg

/* hdl/bvc_edge.sv */
// edge detector for a bus line already in the clock domain
// assumes the line is synchronous to mclk
`timescale 1ns/1ps
module bvc_edge (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // line
    input wire logic line_in,
    output logic rise,
    output logic fall,
    output logic level
);
    logic prev_r;
    // idle bus level is high, so reset to 1 to avoid a false edge
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= line_in;
        end
    end
    assign rise = line_in & ~prev_r;
    assign fall = ~line_in & prev_r;
    assign level = prev_r;
endmodule : bvc_edge

/* hdl/bvc_slew.sv */
// slew engine: walks a channel's target code one step at a time
// assumes step_tick marks one switching cycle
`timescale 1ns/1ps
module bvc_slew #(
    parameter int CODE_W = 7
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // control
    input wire logic step_tick,
    input wire logic apply,
    input wire logic [2:0] slew_code,
    input wire logic [CODE_W-1:0] target,
    // result
    output logic [CODE_W-1:0] present,
    output logic moving
);
    logic [7:0] cnt_r;
    logic [CODE_W-1:0] cur_r;
    logic [7:0] limit;
    logic step_due;
    // 2**n switching cycles per 10 mV step
    assign limit = 8'(8'h01 << slew_code);
    assign step_due = step_tick && (cnt_r + 8'h01 >= limit);
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 8'h00;
            cur_r <= '0;
        end else if (!apply || cur_r == target) begin
            cnt_r <= 8'h00;
            cur_r <= apply ? cur_r : target;
        end else if (step_due) begin
            cnt_r <= 8'h00;
            cur_r <= (cur_r < target) ? CODE_W'(cur_r + 1'b1) : CODE_W'(cur_r - 1'b1);
        end else if (step_tick) begin
            cnt_r <= 8'(cnt_r + 8'h01);
        end
    end
    assign present = cur_r;
    assign moving = apply && (cur_r != target);
endmodule : bvc_slew

/* hdl/bvc_regs.sv */
// What this block does
// RQ1: select bit7 apply; resets zero
// RQ2: low seven bits voltage code, reset zero
// RQ3: code spans 0.68 V to 1.95 V
// RQ4: each code step adds 10 mV
// RQ5: code 00 is 0.68, 7F 1.95
// RQ6: command bits 6..4 slew code, default zero
// RQ7: slew n means 2**n cycles per step
// RQ8: command bit1 picks light-load mode
// RQ9: command bit0 high turns channel off
// RQ10: command bits 7,3,2 spare, read/write, zero
// RQ11: decode 02 ch3 sel, 03/04 commands
// RQ12: every bit readable and writable
// RQ13: controller sends start, address, register, data
// RQ14: data committed at lsb falling clock
// RQ15: only 7-bit addressing, no general call
// RQ16: all enable pins low ignores writes
// RQ17: apply low keeps startup voltage
// RQ18: reads return last write or zero
//
// file holds the two-wire target and the register bank for the buck voltage codes
// assumes scl and sda inputs are synchronous to mclk and the bus pull-ups sit outside
`timescale 1ns/1ps
module bvc_regs
    import bvc_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = bvc_pkg::BVC_TARGET_ADDR
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // two-wire bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // hardware enable pins
    input wire logic [2:0] hw_en,
    // switching cycle tick for the slew engine
    input wire logic sw_tick,
    // channel outputs
    output logic [7:0] ch2_voltage_select,
    output logic [7:0] ch3_voltage_select,
    output logic [7:0] ch1_command,
    output logic [7:0] ch2_command,
    output logic ch2_apply_code,
    output logic ch3_apply_code,
    output logic [6:0] ch2_voltage_code,
    output logic [6:0] ch3_voltage_code,
    output logic [10:0] ch2_target_mv,
    output logic [10:0] ch3_target_mv,
    output logic ch1_light_load_select,
    output logic ch2_light_load_select,
    output logic ch1_off,
    output logic ch2_off
);
    import bvc_pkg::*;

    // code to millivolts; linear, 00 maps to the floor, 7F to the ceiling
    function automatic logic [10:0] code_mv(input logic [6:0] code);
        code_mv = 11'(BVC_VMIN_MV + BVC_VSTEP_MV * int'(code)); // [RQ3] [RQ4] [RQ5]
    endfunction : code_mv

    logic scl_rise, scl_fall, scl_lvl, sda_rise, sda_fall;
    bvc_edge u_scl (.mclk(mclk), .nrst(nrst), .line_in(scl_i), .rise(scl_rise), .fall(scl_fall), .level(scl_lvl));
    bvc_edge u_sda (.mclk(mclk), .nrst(nrst), .line_in(sda_i), .rise(sda_rise), .fall(sda_fall), .level());

    // start and stop conditions: sda moves while scl stays high
    wire start_cond = sda_fall && scl_i && scl_lvl;
    wire stop_cond = sda_rise && scl_i && scl_lvl;

    bvc_state_t st_r, st_nxt;
    logic [7:0] sh_r;
    logic [3:0] bit_r;
    logic [7:0] ptr_r;
    logic rw_r, ptr_set_r, sda_oe_r;
    logic [7:0] ch2_vsel_r, ch3_vsel_r, ch1_cmd_r, ch2_cmd_r;

    // bit_r counts scl rises inside a byte; the scl fall after a start or an
    // acknowledge clock carries no data, so counting rises keeps it out of the tally
    wire last_bit = (bit_r == 4'h8);
    wire [7:0] sh_nxt = {sh_r[6:0], sda_i};
    // at the lsb fall all eight bits already sit in the shifter
    wire [7:0] byte_in = sh_r;
    wire bit_state = (st_r == BVC_ADDR) || (st_r == BVC_REGA) || (st_r == BVC_WDAT) || (st_r == BVC_RDAT);
    // hardware shutdown blocks updates; software off bits do not
    wire hw_shutdown = (hw_en == 3'b000); // [RQ16]
    // only a 7-bit match is answered; general call 00 and 10-bit 11110xx never match
    wire addr_hit = (byte_in[7:1] == TARGET_ADDR) && (TARGET_ADDR != 7'h00)
        && (TARGET_ADDR[6:2] != 5'h1E); // [RQ15]
    wire wr_commit = (st_r == BVC_WDAT) && scl_fall && last_bit && !hw_shutdown; // [RQ14] [RQ16]

    // read mux; unmapped offsets read zero
    logic [7:0] rd_data;
    always_comb begin
        case (ptr_r)
            BVC_OFS_CH2_VSEL: rd_data = ch2_vsel_r; // [RQ18]
            BVC_OFS_CH3_VSEL: rd_data = ch3_vsel_r;
            BVC_OFS_CH1_CMD: rd_data = ch1_cmd_r;
            BVC_OFS_CH2_CMD: rd_data = ch2_cmd_r;
            default: rd_data = 8'h00;
        endcase
    end

    // bus state machine; next state on each falling scl edge
    always_comb begin
        st_nxt = st_r;
        if (scl_fall) begin
            case (st_r)
                BVC_ADDR: st_nxt = last_bit ? (addr_hit ? BVC_ACK : BVC_SKIP) : BVC_ADDR; // [RQ13]
                BVC_REGA: st_nxt = last_bit ? BVC_ACK : BVC_REGA;
                BVC_WDAT: st_nxt = last_bit ? BVC_ACK : BVC_WDAT;
                BVC_ACK: st_nxt = rw_r ? BVC_RDAT : (ptr_set_r ? BVC_WDAT : BVC_REGA);
                BVC_RDAT: st_nxt = last_bit ? BVC_RACK : BVC_RDAT;
                BVC_RACK: st_nxt = BVC_RDAT;
                BVC_IDLE: st_nxt = BVC_IDLE;
                BVC_SKIP: st_nxt = BVC_SKIP;
                default: st_nxt = BVC_IDLE;
            endcase
        end
    end

    // a nack from the controller after a read byte ends the transfer
    wire rd_nack = (st_r == BVC_RACK) && scl_rise && sda_i;

    // sequencing: state, bit counter, shifter
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r <= BVC_IDLE;
            bit_r <= 4'd0;
            sh_r <= 8'h00;
        end else if (start_cond) begin
            st_r <= BVC_ADDR;
            bit_r <= 4'd0;
        end else if (stop_cond || rd_nack) begin
            st_r <= stop_cond ? BVC_IDLE : BVC_SKIP;
        end else begin
            st_r <= st_nxt;
            if (scl_rise) begin
                sh_r <= sh_nxt;
                bit_r <= bit_state ? 4'(bit_r + 4'h1) : bit_r;
            end
            if (scl_fall && (last_bit || st_r == BVC_ACK || st_r == BVC_RACK)) begin
                bit_r <= 4'h0;
            end
        end
    end

    // direction, register pointer and pointer-valid flag
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rw_r <= 1'b0;
            ptr_set_r <= 1'b0;
            ptr_r <= 8'h00;
        end else if (start_cond) begin
            ptr_set_r <= 1'b0; // pointer survives a repeated start
        end else if (scl_fall && last_bit) begin
            if (st_r == BVC_ADDR) begin
                rw_r <= byte_in[0];
            end else if (st_r == BVC_REGA) begin
                ptr_r <= byte_in;
                ptr_set_r <= 1'b1;
            end else if (st_r == BVC_WDAT || st_r == BVC_RDAT) begin
                ptr_r <= 8'(ptr_r + 8'h01); // auto-increment over a burst
            end
        end
    end

    // sda drive: ack low, or read data bits; set on falling scl, released at once on start, stop or read nack
    logic sda_oe_nxt;
    always_comb begin
        sda_oe_nxt = sda_oe_r;
        if (start_cond || stop_cond || rd_nack) begin
            sda_oe_nxt = 1'b0;
        end else if (scl_fall) begin
            case (st_nxt)
                BVC_ACK: sda_oe_nxt = 1'b1; // [RQ13] pull low for the ninth clock
                BVC_RDAT: sda_oe_nxt = ~rd_bit(st_r, bit_r);
                default: sda_oe_nxt = 1'b0;
            endcase
        end
    end

    // bit to put out for the next read slot, msb first
    function automatic logic rd_bit(input bvc_state_t s, input logic [3:0] b);
        logic [2:0] idx;
        idx = (s == BVC_RDAT) ? 3'(3'h7 - b[2:0]) : 3'h7; // b bits already clocked out
        rd_bit = rd_data[idx];
    endfunction : rd_bit

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sda_oe_r <= 1'b0;
        end else begin
            sda_oe_r <= sda_oe_nxt;
        end
    end
    assign sda_oe = sda_oe_r;
    assign sda_o = 1'b0; // open drain: only ever pulls low

    // register bank; every bit writable and readable, all reset to zero
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ch2_vsel_r <= BVC_REG_RESET; // [RQ1] [RQ2]
            ch3_vsel_r <= BVC_REG_RESET;
            ch1_cmd_r <= BVC_REG_RESET; // [RQ6] [RQ10]
            ch2_cmd_r <= BVC_REG_RESET;
        end else if (wr_commit) begin
            case (ptr_r)
                BVC_OFS_CH2_VSEL: ch2_vsel_r <= byte_in; // [RQ12]
                BVC_OFS_CH3_VSEL: ch3_vsel_r <= byte_in; // [RQ11]
                BVC_OFS_CH1_CMD: ch1_cmd_r <= byte_in;
                BVC_OFS_CH2_CMD: ch2_cmd_r <= byte_in;
                default: ;
            endcase
        end
    end

    // slew engines walk the code toward each target
    logic [6:0] ch2_now, ch3_now;
    bvc_slew #(.CODE_W(7)) u_slew2 (.mclk(mclk), .nrst(nrst), .step_tick(sw_tick),
        .apply(ch2_vsel_r[BVC_APPLY_BIT]), .slew_code(ch2_cmd_r[BVC_SLEW_MSB:BVC_SLEW_LSB]),
        .target(ch2_vsel_r[6:0]), .present(ch2_now), .moving()); // [RQ7]
    // channel three has no command register here, so it takes the fastest slew
    bvc_slew #(.CODE_W(7)) u_slew3 (.mclk(mclk), .nrst(nrst), .step_tick(sw_tick),
        .apply(ch3_vsel_r[BVC_APPLY_BIT]), .slew_code(3'b000),
        .target(ch3_vsel_r[6:0]), .present(ch3_now), .moving());

    // registered channel outputs; apply low zeroes the millivolt target so the analog side keeps its strapped start-up level
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ch2_voltage_select <= BVC_REG_RESET;
            ch3_voltage_select <= BVC_REG_RESET;
            ch1_command <= BVC_REG_RESET;
            ch2_command <= BVC_REG_RESET;
            ch2_apply_code <= 1'b0;
            ch3_apply_code <= 1'b0;
            ch2_voltage_code <= BVC_CODE_MIN;
            ch3_voltage_code <= BVC_CODE_MIN;
            ch2_target_mv <= 11'd0;
            ch3_target_mv <= 11'd0;
            ch1_light_load_select <= 1'b0;
            ch2_light_load_select <= 1'b0;
            ch1_off <= 1'b0;
            ch2_off <= 1'b0;
        end else begin
            ch2_voltage_select <= ch2_vsel_r;
            ch3_voltage_select <= ch3_vsel_r;
            ch1_command <= ch1_cmd_r;
            ch2_command <= ch2_cmd_r;
            ch2_apply_code <= ch2_vsel_r[BVC_APPLY_BIT]; // [RQ1] [RQ17]
            ch3_apply_code <= ch3_vsel_r[BVC_APPLY_BIT];
            ch2_voltage_code <= ch2_now; // [RQ2]
            ch3_voltage_code <= ch3_now;
            ch2_target_mv <= ch2_vsel_r[BVC_APPLY_BIT] ? code_mv(ch2_now) : 11'd0; // [RQ17]
            ch3_target_mv <= ch3_vsel_r[BVC_APPLY_BIT] ? code_mv(ch3_now) : 11'd0;
            ch1_light_load_select <= ch1_cmd_r[BVC_LIGHT_LOAD_BIT]; // [RQ8]
            ch2_light_load_select <= ch2_cmd_r[BVC_LIGHT_LOAD_BIT];
            ch1_off <= ch1_cmd_r[BVC_OFF_BIT]; // [RQ9]
            ch2_off <= ch2_cmd_r[BVC_OFF_BIT];
        end
    end

    // assertions
    a_reset_regs_zero: assert property (@(posedge mclk) // [RQ1]
        $rose(nrst) |-> ch2_vsel_r == 8'h00 && ch1_cmd_r == 8'h00)
        else $error("registers not zero after reset");
    a_commit_stores_byte: assert property (@(posedge mclk) disable iff (!nrst) // [RQ11] [RQ14]
        wr_commit && ptr_r == BVC_OFS_CH3_VSEL |=> ch3_vsel_r == $past(byte_in))
        else $error("ch3 select did not take the byte");
    a_shutdown_blocks: assert property (@(posedge mclk) disable iff (!nrst) // [RQ16]
        hw_shutdown |=> $stable(ch1_cmd_r) && $stable(ch2_vsel_r))
        else $error("write accepted in hardware shutdown");
    // checked on the output port, so a slip between code and millivolts shows
    a_mv_ceiling: assert property (@(posedge mclk) disable iff (!nrst) // [RQ5]
        ch3_apply_code && ch3_voltage_code == BVC_CODE_MAX |-> ch3_target_mv == 11'(BVC_VMAX_MV))
        else $error("code map top end wrong");
    a_mv_floor: assert property (@(posedge mclk) disable iff (!nrst) // [RQ3] [RQ5]
        ch3_apply_code && ch3_voltage_code == BVC_CODE_MIN |-> ch3_target_mv == 11'(BVC_VMIN_MV))
        else $error("code map bottom end wrong");
    a_off_follows_cmd: assert property (@(posedge mclk) disable iff (!nrst) // [RQ9]
        ##1 ch1_off == $past(ch1_cmd_r[BVC_OFF_BIT]))
        else $error("off output lags command");
    a_mode_follows_cmd: assert property (@(posedge mclk) disable iff (!nrst) // [RQ8]
        ##1 ch2_light_load_select == $past(ch2_cmd_r[BVC_LIGHT_LOAD_BIT]))
        else $error("light-load output wrong");
    a_apply_low_parks: assert property (@(posedge mclk) disable iff (!nrst) // [RQ17]
        !ch3_vsel_r[BVC_APPLY_BIT] |=> ch3_target_mv == 11'h000)
        else $error("code used while apply low");
    sequence s_hit_addr;
        st_r == BVC_ADDR && scl_fall && last_bit && addr_hit;
    endsequence
    a_ack_after_addr: assert property (@(posedge mclk) disable iff (!nrst) // [RQ13]
        s_hit_addr ##0 !stop_cond && !start_cond |=> sda_oe)
        else $error("no ack on matching address");
    a_no_general_call: assert property (@(posedge mclk) disable iff (!nrst) // [RQ15]
        st_r == BVC_ADDR && scl_fall && last_bit && byte_in[7:1] == 7'h00 |=> st_r != BVC_ACK)
        else $error("general call answered");
    a_no_ten_bit: assert property (@(posedge mclk) disable iff (!nrst) // [RQ15]
        st_r == BVC_ADDR && scl_fall && last_bit && byte_in[7:3] == 5'h1E |=> st_r != BVC_ACK)
        else $error("ten-bit header answered");
    a_slew_step_size: assert property (@(posedge mclk) disable iff (!nrst) // [RQ4] [RQ7]
        ch2_vsel_r[BVC_APPLY_BIT] && $past(ch2_vsel_r[BVC_APPLY_BIT]) && ch2_now != $past(ch2_now)
        |-> (ch2_now == 7'($past(ch2_now) + 1'b1)) || (ch2_now == 7'($past(ch2_now) - 1'b1)))
        else $error("slew moved more than one step");
endmodule : bvc_regs

/* test/bvc_i2c_ctrl.sv */
// two-wire bus controller model: start, stop, register writes and single-byte reads
// assumes a pull-up outside, so a released data line reads high
`timescale 1ns/1ps
module bvc_i2c_ctrl #(
    parameter int HALF = 4
) (
    // clock
    input wire logic mclk,
    // bus lines
    output logic scl,
    output logic sda_low,
    input wire logic sda_in,
    // read result
    output logic rd_stb,
    output logic [7:0] rd_byte
);
    // idle bus: both lines released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        rd_stb = 1'b0;
        rd_byte = 8'h00;
    end
    // lines only move just after an mclk edge
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : wt
    // start and repeated start: data falls while the clock is high
    task automatic start_cond();
        sda_low = 1'b0;
        wt(HALF);
        scl = 1'b1;
        wt(HALF);
        sda_low = 1'b1;
        wt(HALF);
        scl = 1'b0;
        wt(HALF);
    endtask : start_cond
    // stop: data rises while the clock is high
    task automatic stop_cond();
        sda_low = 1'b1;
        wt(HALF);
        scl = 1'b1;
        wt(HALF);
        sda_low = 1'b0;
        wt(HALF);
    endtask : stop_cond
    // data moves HALF mclk cycles after the fall, midway through the low time, so it never changes with the clock high
    task automatic clk_bit(input logic b, output logic s);
        sda_low = ~b;
        wt(HALF);
        scl = 1'b1;
        wt(HALF);
        s = sda_in;
        scl = 1'b0;
        wt(HALF);
    endtask : clk_bit
    // byte out msb first; the ninth clock samples the acknowledge
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
        end
        clk_bit(1'b1, s);
        ack = ~s;
    endtask : send_byte
    // single update: target address, register byte, one data byte
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] dat, output logic ok);
        logic [2:0] a;
        start_cond();
        send_byte({dev, 1'b0}, a[0]);
        send_byte(ofs, a[1]);
        send_byte(dat, a[2]);
        stop_cond();
        ok = &a;
    endtask : write_reg
    // read one byte after a repeated start; the nack ends the read
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs);
        logic a;
        logic [7:0] b;
        start_cond();
        send_byte({dev, 1'b0}, a);
        send_byte(ofs, a);
        start_cond();
        send_byte({dev, 1'b1}, a);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, b[i]);
        end
        clk_bit(1'b1, a);
        stop_cond();
        rd_byte = b;
        rd_stb = 1'b1;
        wt(1);
        rd_stb = 1'b0;
    endtask : read_reg
endmodule : bvc_i2c_ctrl

/* test/test_buck_vid_command_registers.sv */
// self-checking bench for the voltage-code register bank behind its two-wire target
// assumes the controller model bvc_i2c_ctrl and a pull-up on the data line
`timescale 1ns/1ps
module test_buck_vid_command_registers
    import bvc_pkg::*;
;
    localparam int LIMIT = 80000;
    logic mclk, nrst, sw_tick, sda_o, sda_oe, scl, ctl_low, rd_stb, ack;
    logic ch2_apply, ch3_apply, ch1_ll, ch2_ll, ch1_off, ch2_off;
    logic [2:0] hw_en;
    logic [6:0] ch2_code, ch3_code;
    logic [7:0] ch2_vsel, ch3_vsel, ch1_cmd, ch2_cmd, rd_byte, d, o;
    logic [10:0] ch2_mv, ch3_mv;
    logic [7:0] mir [0:7];
    logic [6:0] bad_dev [3];
    logic [31:0] exp_q [$];
    int error_cnt, cmp_count, cyc, seed;
    // open-drain data line with pull-up
    wire sda = ~(ctl_low | (sda_oe & ~sda_o));

    bvc_regs i_dut (.mclk(mclk), .nrst(nrst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .hw_en(hw_en), .sw_tick(sw_tick), .ch2_voltage_select(ch2_vsel), .ch3_voltage_select(ch3_vsel),
        .ch1_command(ch1_cmd), .ch2_command(ch2_cmd), .ch2_apply_code(ch2_apply), .ch3_apply_code(ch3_apply),
        .ch2_voltage_code(ch2_code), .ch3_voltage_code(ch3_code), .ch2_target_mv(ch2_mv), .ch3_target_mv(ch3_mv),
        .ch1_light_load_select(ch1_ll), .ch2_light_load_select(ch2_ll), .ch1_off(ch1_off), .ch2_off(ch2_off));
    bvc_i2c_ctrl u_ctl (.mclk(mclk), .scl(scl), .sda_low(ctl_low), .sda_in(sda), .rd_stb(rd_stb), .rd_byte(rd_byte));

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : chk
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    // write through the bus; the model of stored contents only moves when a write may land
    task automatic wr(input logic [7:0] ofs, input logic [7:0] dat);
        u_ctl.write_reg(BVC_TARGET_ADDR, ofs, dat, ack);
        chk(ack, 32'h1);
        if (ofs >= 8'h01 && ofs <= 8'h04 && hw_en != 3'h0) begin
            mir[ofs[2:0]] = dat;
        end
    endtask : wr
    // the expected byte is noted first, the watcher compares it when the read lands
    task automatic rd(input logic [7:0] ofs, input logic [7:0] want);
        exp_q.push_back({24'h0, want});
        u_ctl.read_reg(BVC_TARGET_ADDR, ofs);
    endtask : rd
    // switching cycles, then room for the two-stage output lag
    task automatic ticks(input int n);
        repeat (n) begin
            sw_tick = 1'b1;
            @(posedge mclk);
            #1 sw_tick = 1'b0;
            @(posedge mclk);
            #1;
        end
        repeat (3) @(posedge mclk);
        #1;
    endtask : ticks
    function automatic logic [7:0] port_of(input logic [7:0] ofs);
        case (ofs)
            8'h01: port_of = ch2_vsel;
            8'h02: port_of = ch3_vsel;
            8'h03: port_of = ch1_cmd;
            default: port_of = ch2_cmd;
        endcase
    endfunction : port_of

    initial begin
        mclk = 1'b0;
        forever #(BVC_CLK_NS / 2) mclk = ~mclk;
    end
    // watcher: every finished read takes the oldest note
    always @(posedge mclk) begin
        if (rd_stb === 1'b1) begin
            chk({24'h0, rd_byte}, exp_q.pop_front());
        end
    end
    // hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            complete_run();
        end
    end

    initial begin
        seed = 32'h49bd;
        nrst = 1'b0;
        hw_en = 3'h7;
        sw_tick = 1'b0;
        bad_dev = '{BVC_TARGET_ADDR ^ 7'h01, 7'h00, 7'h78};
        for (int i = 0; i < 8; i++) mir[i] = 8'h00;
        repeat (20) @(posedge mclk);
        #1 nrst = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        chk({ch2_apply, ch3_apply, ch2_code, ch3_code}, 32'h0);
        chk({ch1_cmd[6:4], ch2_cmd[6:4], ch1_ll, ch2_ll, ch1_off, ch2_off}, 32'h0);
        for (int k = 1; k <= 4; k++) rd(8'(k), 8'h00);
        // random contents, spare bits included, seen at the ports and read back
        for (int k = 0; k < 12; k++) begin
            o = 8'(1 + k % 4);
            d = 8'($random(seed));
            wr(o, d);
            chk(port_of(o), d);
            chk({ch1_ll, ch1_off, ch2_ll, ch2_off}, {mir[3][1:0], mir[4][1:0]});
            rd(o, d);
        end
        // unmapped offsets keep the bank unchanged
        wr(8'h05, 8'hA5);
        wr(8'h00, 8'h5A);
        for (int k = 0; k <= 5; k++) rd(8'(k), mir[k]);
        // foreign, general call and ten-bit headers get no acknowledge
        foreach (bad_dev[i]) begin
            u_ctl.write_reg(bad_dev[i], 8'h02, 8'hFF, ack);
            chk(ack, 32'h0);
        end
        rd(8'h02, mir[2]);
        // hardware shutdown blocks writes; register-only disable does not
        hw_en = 3'h0;
        wr(8'h03, ~mir[3]);
        rd(8'h03, mir[3]);
        hw_en = 3'h4;
        wr(8'h03, 8'h01);
        wr(8'h04, 8'h01);
        rd(8'h04, 8'h01);
        // channel three uses the fastest slew, so settle with plenty of cycles
        wr(8'h02, 8'h33);
        ticks(200);
        chk({ch3_apply, ch3_mv}, 32'h0);
        foreach (bad_dev[i]) begin
            d = (i == 0) ? 8'h80 : ((i == 1) ? 8'hFF : 8'hAA);
            wr(8'h02, d);
            ticks(200);
            chk({ch3_apply, ch3_code}, d);
            chk(ch3_mv, BVC_VMIN_MV + BVC_VSTEP_MV * d[6:0]);
        end
        // every slew code: three steps must not finish early nor late
        for (int n = 0; n < 8; n++) begin
            // apply low first: the code jumps to zero unslewed, whatever came before
            wr(8'h01, 8'h00);
            chk({ch2_apply, ch2_mv, ch2_code}, 32'h0);
            wr(8'h01, 8'h80);
            wr(8'h04, 8'(n << 4));
            ticks(4 << n);
            chk(ch2_code, 32'h0);
            wr(8'h01, 8'h83);
            ticks(2 << n);
            chk(ch2_code, 32'h2);
            ticks(1 << n);
            chk(ch2_code, 32'h3);
            chk({ch2_cmd[6:4], ch2_mv}, {n[2:0], 11'(BVC_VMIN_MV + 3 * BVC_VSTEP_MV)});
        end
        // second reset in mid-run clears the bank
        nrst = 1'b0;
        repeat (2) @(posedge mclk);
        #1 nrst = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        chk(ch2_cmd, 32'h0);
        rd(8'h04, 8'h00);
        complete_run();
    end
endmodule : test_buck_vid_command_registers
